// ==== rtl/rft_cfg.svh ====
`ifndef RFT_CFG_SVH
`define RFT_CFG_SVH
// spi opcodes, top three bits of the first byte
`define RFT_OP_WR_STATE 3'h1
`define RFT_OP_RD_STATE 3'h2
`define RFT_OP_RD_IRQ 3'h3
`define RFT_OP_WR_MASK 3'h4
`define RFT_OP_WR_FB 3'h5
`define RFT_OP_RD_FB 3'h6
`define RFT_OP_CAL 3'h7
// command field values written with RFT_OP_WR_STATE
`define RFT_CMD_TX_START 4'h2
`define RFT_CMD_LISTEN 4'h6
`define RFT_CMD_IDLE 4'h8
`define RFT_CMD_SYN_READY 4'h9
`define RFT_CMD_AACK 4'hA
`define RFT_CMD_ARET 4'hB
// interrupt status bit positions
`define RFT_IRQ_DETECT 0
`define RFT_IRQ_END 1
`define RFT_IRQ_UR 2
`define RFT_IRQ_CAL 3
`define RFT_IRQ_RST 4'h0
`define RFT_MASK_RST 4'h0
// link sync reset value: {sleep_tx_trigger_pin, cs_n, mosi, sclk}, cs_n idle high
`define RFT_SYNC_RST 4'h4
// timing
`define RFT_CLK_MHZ 250
`define RFT_RX_HOLD_US 32
`define RFT_RX_HOLD_CYC (`RFT_RX_HOLD_US * `RFT_CLK_MHZ)
`define RFT_SYM_US 16
`define RFT_SYM_CYC (`RFT_SYM_US * `RFT_CLK_MHZ)
`define RFT_STARTUP_SYM 1
`define RFT_SHR_BPSK_SYM 40
`define RFT_SHR_OQPSK_SYM 10
`define RFT_CAL_CYC 64
`define RFT_SCK_HALF 20
`define RFT_RECAL_S 300
`endif

// ==== rtl/rft_device.sv ====
// Operation
// - auto filter calibration entering idle from pon/sleep
// - host requests calibration only in listed states; device accepts the opcode in any state
// - host repeats calibration at most five minutes
// - calibration result trims baseband and loop filter
// - listen states search for frames
// - frame detect raises detect interrupt
// - reception end raises frame end interrupt
// - first byte readable 32us after detect
// - host reads slower than bytes arrive
// - reading past data raises underrun interrupt
// - host may wait for frame end
// - buffer empty indication paces host reads
// - trigger by pin or launch command
// - host triggers only in ready states
// - transmission end raises frame end interrupt
// - trigger allowed before buffer is written
// - sync header generated internally
// - one symbol front end startup first
// - header 40 symbols bpsk, 10 oqpsk
// - host writes phy header before header ends
// - slow host writes cause underrun interrupt
// - host reads received data over spi
`timescale 1ns/1ps
`include "rft_cfg.svh"
module rft_device import rft_pkg::*; #(
  parameter int RX_HOLD_CYC = `RFT_RX_HOLD_CYC,
  parameter int SYM_CYC = `RFT_SYM_CYC
) (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // sync reset, active low
  rft_link_if.dev link, // spi, irq and trigger pin
  input wire logic i_oqpsk, // 1 = oqpsk header length
  input wire logic i_rx_start, // demodulator found a frame
  input wire logic i_rx_valid, // received byte strobe
  input wire logic [7:0] i_rx_byte, // received byte
  input wire logic i_rx_end, // reception finished
  output logic o_rx_ready, // buffer can take a byte
  input wire logic i_tx_ready, // modulator requests a byte
  output logic o_tx_valid, // byte for modulator
  output logic [7:0] o_tx_byte, // byte value
  output logic o_tx_shr, // modulator sends internal header
  output logic o_fe_on, // front end running
  input wire logic [7:0] i_tune_code, // measured filter tuning code
  output logic o_cal_busy, // calibration running
  output logic [7:0] o_bb_trim, // baseband filter trim
  output logic [7:0] o_lf_tc, // loop filter time constant
  output logic [3:0] o_state // current transceiver state
);
  rft_state_type state_ff, ret_ff;
  rft_tx_phase_type phase_ff;
  logic [3:0] s1_ff, s2_ff, s3_ff, flt_ff, prev_ff;
  logic [4:0] bit_ff;
  logic [6:0] sh_in_ff;
  logic [2:0] op_ff;
  logic [7:0] tx_sh_ff;
  logic [3:0] irq_ff, mask_ff, irq_set;
  logic [31:0] cyc_ff;
  logic [5:0] sym_ff;
  logic [31:0] hold_ff;
  logic hold_done_ff;
  logic [6:0] cal_ff;
  logic first_ff;
  logic [6:0] left_ff;
  logic miso_ff, irq_out_ff;
  logic sck_rise, sck_fall, slp_rise, slp_fall, cs_idle;
  logic rd_evt, wr_evt, wr_cmd, trig, tx_pop, spi_pop, spi_push, tx_end, sym_end;
  logic fb_ok, rx_mode, enter_idle;
  logic [7:0] nxt_byte, rdata;
  logic [2:0] op_now;
  logic [5:0] shr_len;
  logic fi_valid, fi_ready, fo_valid, fo_ready, flush;
  logic [7:0] fi_data, fo_data;

  function automatic logic is_rx(input rft_state_type s);
    return s == ST_LISTEN || s == ST_AACK || s == ST_BUSY_RX;
  endfunction

  // three-stage sync per link input; a change counts when stages 2 and 3 agree
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        s1_ff[g] <= 1'(`RFT_SYNC_RST >> g);
        s2_ff[g] <= 1'(`RFT_SYNC_RST >> g);
        s3_ff[g] <= 1'(`RFT_SYNC_RST >> g);
        flt_ff[g] <= 1'(`RFT_SYNC_RST >> g);
        prev_ff[g] <= 1'(`RFT_SYNC_RST >> g);
      end else begin
        s1_ff[g] <= (g == 0) ? link.sclk : (g == 1) ? link.mosi :
                    (g == 2) ? link.cs_n : link.sleep_tx_trigger_pin;
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        flt_ff[g] <= (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : flt_ff[g];
        prev_ff[g] <= flt_ff[g];
      end
    end
  end

  assign sck_rise = flt_ff[0] && !prev_ff[0] && !flt_ff[2];
  assign sck_fall = !flt_ff[0] && prev_ff[0] && !flt_ff[2];
  assign cs_idle = flt_ff[2];
  assign slp_rise = flt_ff[3] && !prev_ff[3];
  assign slp_fall = !flt_ff[3] && prev_ff[3];
  assign nxt_byte = {sh_in_ff, flt_ff[1]};
  assign op_now = nxt_byte[7:5];
  assign rd_evt = sck_rise && bit_ff == 5'h07;
  assign wr_evt = sck_rise && bit_ff == 5'h0F;
  assign wr_cmd = wr_evt && op_ff == `RFT_OP_WR_STATE;
  assign rx_mode = is_rx(state_ff);
  assign fb_ok = fo_valid && (!rx_mode || hold_done_ff);
  assign spi_pop = rd_evt && op_now == `RFT_OP_RD_FB && fb_ok;
  assign spi_push = wr_evt && op_ff == `RFT_OP_WR_FB;
  assign trig = slp_rise || (wr_cmd && nxt_byte[3:0] == `RFT_CMD_TX_START);
  assign enter_idle = state_ff == ST_PON || (state_ff == ST_SLEEP && slp_fall);
  assign sym_end = cyc_ff == 32'(SYM_CYC - 1);
  assign shr_len = i_oqpsk ? 6'(`RFT_SHR_OQPSK_SYM) : 6'(`RFT_SHR_BPSK_SYM);
  assign tx_pop = state_ff == ST_BUSY_TX && phase_ff == TX_DATA && i_tx_ready && fo_valid
                  && (first_ff || left_ff != 7'h00);
  assign tx_end = state_ff == ST_BUSY_TX && phase_ff == TX_DATA && !first_ff
                  && left_ff == 7'h00;
  assign flush = (state_ff == ST_LISTEN || state_ff == ST_AACK) && i_rx_start;

  // one buffer serves both directions; its owner follows the state
  assign fi_valid = rx_mode ? (i_rx_valid && state_ff == ST_BUSY_RX) : spi_push;
  assign fi_data = rx_mode ? i_rx_byte : nxt_byte;
  assign fo_ready = rx_mode ? spi_pop : tx_pop;
  assign o_rx_ready = fi_ready;

  rft_fifo #(.W(8), .D(8)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_flush(flush),
    .i_in_valid(fi_valid),
    .i_in_data(fi_data),
    .o_in_ready(fi_ready),
    .o_out_valid(fo_valid),
    .o_out_data(fo_data),
    .i_out_ready(fo_ready)
  );

  // spi bit counter and input shifter, restarted while chip select is high
  always_ff @(posedge i_clk) begin
    if (!i_rstn || cs_idle) begin
      bit_ff <= 5'h00;
      sh_in_ff <= 7'h00;
      op_ff <= 3'h0;
    end else if (sck_rise) begin
      sh_in_ff <= nxt_byte[6:0];
      bit_ff <= 5'(bit_ff + 5'h01);
      op_ff <= rd_evt ? op_now : op_ff;
    end
  end

  // read answer; empty flag in bit 7 of the state byte
  always_comb begin
    rdata = 8'h00;
    unique case (op_now)
      `RFT_OP_RD_STATE: rdata = {!fo_valid, 3'h0, o_state};
      `RFT_OP_RD_IRQ: rdata = {4'h0, irq_ff};
      `RFT_OP_RD_FB: rdata = fb_ok ? fo_data : 8'h00;
      default: rdata = 8'h00;
    endcase
  end

  // output shifter, msb first on falling sclk from the ninth bit
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tx_sh_ff <= 8'h00;
      miso_ff <= 1'b0;
    end else if (rd_evt) begin
      tx_sh_ff <= rdata;
    end else if (sck_fall && bit_ff >= 5'h08) begin
      miso_ff <= tx_sh_ff[7];
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // transceiver state and transmit phases
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_ff <= ST_PON;
      ret_ff <= ST_SYN;
      phase_ff <= TX_STARTUP;
      cyc_ff <= 32'h0;
      sym_ff <= 6'h00;
    end else begin
      cyc_ff <= (state_ff != ST_BUSY_TX || sym_end) ? 32'h0 : 32'(cyc_ff + 32'h1);
      unique case (state_ff)
        ST_PON: state_ff <= ST_IDLE;
        ST_SLEEP: state_ff <= slp_fall ? ST_IDLE : ST_SLEEP;
        ST_BUSY_RX: state_ff <= i_rx_end ? ret_ff : ST_BUSY_RX;
        ST_LISTEN, ST_AACK: begin
          if (i_rx_start) begin
            ret_ff <= state_ff;
            state_ff <= ST_BUSY_RX;
          end else if (wr_cmd && nxt_byte[3:0] == `RFT_CMD_IDLE) begin
            state_ff <= ST_IDLE;
          end else if (wr_cmd && nxt_byte[3:0] == `RFT_CMD_SYN_READY) begin
            state_ff <= ST_SYN;
          end
        end
        ST_BUSY_TX: begin
          if (phase_ff == TX_STARTUP && sym_end) begin
            phase_ff <= TX_SHR;
            sym_ff <= 6'h00;
          end else if (phase_ff == TX_SHR && sym_end) begin
            sym_ff <= 6'(sym_ff + 6'h01);
            phase_ff <= (sym_ff == 6'(shr_len - 6'h01)) ? TX_DATA : TX_SHR;
          end else if (tx_end) begin
            state_ff <= ret_ff;
          end
        end
        default: begin
          // idle, synthesizer ready and auto retry ready
          if (trig && (state_ff == ST_SYN || state_ff == ST_ARET)) begin
            ret_ff <= state_ff;
            phase_ff <= TX_STARTUP;
            state_ff <= ST_BUSY_TX;
          end else if (state_ff == ST_IDLE && slp_rise) begin
            state_ff <= ST_SLEEP;
          end else if (wr_cmd) begin
            unique case (nxt_byte[3:0])
              `RFT_CMD_IDLE: state_ff <= ST_IDLE;
              `RFT_CMD_SYN_READY: state_ff <= ST_SYN;
              `RFT_CMD_LISTEN: state_ff <= ST_LISTEN;
              `RFT_CMD_AACK: state_ff <= ST_AACK;
              `RFT_CMD_ARET: state_ff <= ST_ARET;
              default: state_ff <= state_ff;
            endcase
          end
        end
      endcase
    end
  end

  // payload drain: first byte is the phy header carrying the length
  always_ff @(posedge i_clk) begin
    if (!i_rstn || state_ff != ST_BUSY_TX) begin
      first_ff <= 1'b1;
      left_ff <= 7'h00;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
    end else begin
      o_tx_valid <= tx_pop;
      if (tx_pop) begin
        o_tx_byte <= fo_data;
        first_ff <= 1'b0;
        left_ff <= first_ff ? fo_data[6:0] : 7'(left_ff - 7'h01);
      end
    end
  end

  // header is produced by the modulator itself, never read from the buffer
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_tx_shr <= 1'b0;
      o_fe_on <= 1'b0;
      o_state <= 4'h0;
    end else begin
      o_tx_shr <= state_ff == ST_BUSY_TX && phase_ff == TX_SHR;
      o_fe_on <= state_ff == ST_BUSY_TX;
      o_state <= state_ff;
    end
  end

  // read hold-off after detect so the host cannot fetch an empty first byte
  always_ff @(posedge i_clk) begin
    if (!i_rstn || flush) begin
      hold_ff <= 32'h0;
      hold_done_ff <= 1'b0;
    end else if (!hold_done_ff) begin
      hold_ff <= 32'(hold_ff + 32'h1);
      hold_done_ff <= hold_ff == 32'(RX_HOLD_CYC - 1);
    end
  end

  // filter calibration, automatic on idle entry from pon or sleep, manual by opcode anytime
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cal_ff <= 7'h00;
      o_cal_busy <= 1'b0;
      o_bb_trim <= 8'h80;
      o_lf_tc <= 8'h40;
    end else if (enter_idle || (wr_evt && op_ff == `RFT_OP_CAL)) begin
      cal_ff <= 7'h00;
      o_cal_busy <= 1'b1;
    end else if (o_cal_busy) begin
      cal_ff <= 7'(cal_ff + 7'h01);
      if (cal_ff == 7'(`RFT_CAL_CYC - 1)) begin
        o_cal_busy <= 1'b0;
        o_bb_trim <= i_tune_code;
        o_lf_tc <= {1'b0, i_tune_code[7:1]};
      end
    end
  end

  // interrupt sources
  always_comb begin
    irq_set = 4'h0;
    irq_set[`RFT_IRQ_DETECT] = flush;
    irq_set[`RFT_IRQ_END] = (state_ff == ST_BUSY_RX && i_rx_end) || tx_end;
    irq_set[`RFT_IRQ_UR] = (rd_evt && op_now == `RFT_OP_RD_FB && !fb_ok)
      || (state_ff == ST_BUSY_TX && phase_ff == TX_DATA && i_tx_ready && !fo_valid
          && !tx_end);
    irq_set[`RFT_IRQ_CAL] = o_cal_busy && cal_ff == 7'(`RFT_CAL_CYC - 1);
  end

  // sticky status cleared by its read, a new event in that cycle survives
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_ff <= `RFT_IRQ_RST;
      mask_ff <= `RFT_MASK_RST;
      irq_out_ff <= 1'b0;
    end else begin
      irq_ff <= (irq_ff & ~{4{rd_evt && op_now == `RFT_OP_RD_IRQ}}) | irq_set;
      mask_ff <= (wr_evt && op_ff == `RFT_OP_WR_MASK) ? nxt_byte[3:0] : mask_ff;
      irq_out_ff <= |(irq_ff & mask_ff);
    end
  end

  assign link.miso = miso_ff;
  assign link.irq = irq_out_ff;
endmodule

// ==== rtl/rft_fifo.sv ====
`timescale 1ns/1ps
module rft_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // sync reset, active low
  input wire logic i_flush, // drop all contents
  input wire logic i_in_valid, // write request
  input wire logic [W-1:0] i_in_data, // write data
  output logic o_in_ready, // room left
  output logic o_out_valid, // data present
  output logic [W-1:0] o_out_data, // head word
  input wire logic i_out_ready // pop request
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  logic [AW:0] nxt_cnt;

  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign o_out_data = mem_ff[rd_ff];
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // storage is not reset, only pointers, count and flags are
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // pointers, count and flags held as registers so ready and valid are clean
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_flush) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      wr_ff <= push ? AW'(wr_ff + 1'b1) : wr_ff;
      rd_ff <= pop ? AW'(rd_ff + 1'b1) : rd_ff;
      cnt_ff <= nxt_cnt;
      o_in_ready <= nxt_cnt != (AW+1)'(D);
      o_out_valid <= nxt_cnt != '0;
    end
  end
endmodule

// ==== rtl/rft_host.sv ====
`timescale 1ns/1ps
`include "rft_cfg.svh"
module rft_host import rft_pkg::*; #(
  parameter logic [39:0] RECAL_CYC = 40'(`RFT_RECAL_S) * 40'(`RFT_CLK_MHZ) * 40'd1000000
) (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // sync reset, active low
  rft_link_if.host link, // spi, irq and trigger pin
  input wire logic i_cmd_valid, // start one spi transfer
  input wire logic [2:0] i_cmd_op, // opcode
  input wire logic [7:0] i_cmd_data, // write byte
  output logic o_cmd_ready, // link idle
  output logic o_rsp_valid, // transfer done pulse
  output logic [7:0] o_rsp_data, // byte read back
  input wire logic i_sleep_tx_trigger_pin, // level for the trigger pin
  output logic o_irq, // synchronised interrupt line
  output logic o_recal_due // manual calibration is due
);
  rft_host_state_type st_ff;
  logic [15:0] sh_ff;
  logic [7:0] rx_ff;
  logic [5:0] edge_ff;
  logic [4:0] half_ff;
  logic sclk_ff, cs_n_ff, mosi_ff, slp_ff;
  logic i1_ff, i2_ff, i3_ff;
  logic [39:0] recal_ff;
  logic tick, accept;

  assign tick = half_ff == 5'(`RFT_SCK_HALF - 1);
  assign accept = st_ff == H_IDLE && i_cmd_valid;

  // sclk divider and transfer sequencer, spi mode 0, sixteen bits
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= H_IDLE;
      half_ff <= 5'h00;
      edge_ff <= 6'h00;
      sh_ff <= 16'h0000;
      rx_ff <= 8'h00;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 8'h00;
      o_cmd_ready <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      half_ff <= (st_ff == H_IDLE || tick) ? 5'h00 : 5'(half_ff + 5'h01);
      unique case (st_ff)
        H_IDLE: begin
          o_cmd_ready <= !i_cmd_valid;
          if (accept) begin
            st_ff <= H_XFER;
            sh_ff <= {i_cmd_op, 5'h00, i_cmd_data};
            mosi_ff <= i_cmd_op[2];
            cs_n_ff <= 1'b0;
            edge_ff <= 6'h00;
          end
        end
        H_XFER: begin
          if (tick) begin
            edge_ff <= 6'(edge_ff + 6'h01);
            if (edge_ff == 6'h20) begin
              cs_n_ff <= 1'b1;
              o_rsp_valid <= 1'b1;
              o_rsp_data <= rx_ff;
              st_ff <= H_GAP;
            end else if (!edge_ff[0]) begin
              sclk_ff <= 1'b1;
              rx_ff <= {rx_ff[6:0], link.miso};
            end else begin
              sclk_ff <= 1'b0;
              sh_ff <= {sh_ff[14:0], 1'b0};
              mosi_ff <= sh_ff[14];
            end
          end
        end
        default: begin
          // chip select stays high long enough for the far sync to see it
          if (tick) begin
            st_ff <= H_IDLE;
            o_cmd_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  // interrupt input through three flops, change taken when stages agree
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      i1_ff <= 1'b0;
      i2_ff <= 1'b0;
      i3_ff <= 1'b0;
      o_irq <= 1'b0;
      slp_ff <= 1'b0;
    end else begin
      i1_ff <= link.irq;
      i2_ff <= i1_ff;
      i3_ff <= i2_ff;
      o_irq <= (i2_ff == i3_ff) ? i3_ff : o_irq;
      slp_ff <= i_sleep_tx_trigger_pin; // user keeps it to ready states
    end
  end

  // recalibration reminder; restarted when a calibration opcode is sent
  always_ff @(posedge i_clk) begin
    if (!i_rstn || (accept && i_cmd_op == `RFT_OP_CAL)) begin
      recal_ff <= 40'h0;
      o_recal_due <= 1'b0;
    end else begin
      recal_ff <= o_recal_due ? recal_ff : 40'(recal_ff + 40'h1);
      o_recal_due <= o_recal_due || recal_ff == 40'(RECAL_CYC - 40'h1);
    end
  end

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
  assign link.sleep_tx_trigger_pin = slp_ff;
endmodule

// ==== rtl/rft_link_if.sv ====
`timescale 1ns/1ps
interface rft_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq;
  logic sleep_tx_trigger_pin;
  modport dev (input sclk, input cs_n, input mosi, input sleep_tx_trigger_pin, output miso, output irq);
  modport host (output sclk, output cs_n, output mosi, output sleep_tx_trigger_pin, input miso, input irq);
endinterface

// ==== rtl/rft_pkg.sv ====
package rft_pkg;
  typedef enum logic [3:0] {
    ST_PON, ST_SLEEP, ST_IDLE, ST_SYN, ST_LISTEN, ST_AACK, ST_ARET, ST_BUSY_TX, ST_BUSY_RX
  } rft_state_type;
  typedef enum logic [1:0] {TX_STARTUP, TX_SHR, TX_DATA} rft_tx_phase_type;
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_GAP} rft_host_state_type;
endpackage

// ==== test/rft_link_sva.sv ====
`timescale 1ns/1ps
module rft_link_sva (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // sync reset, active low
  input wire logic sclk, // spi clock
  input wire logic cs_n, // chip select, active low
  input wire logic mosi, // host data
  input wire logic miso, // device data
  input wire logic irq, // interrupt line
  input wire logic sleep_tx_trigger_pin // trigger pin
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [4:0] gap_ff;
  logic [4:0] rise_ff;
  logic sclk_d_ff;
  // idle time between frames, saturating; a repetition of 20 would be too long
  always_ff @(posedge i_clk) begin
    if (!i_rstn) gap_ff <= 5'h14;
    else if (!cs_n) gap_ff <= 5'h00;
    else if (gap_ff != 5'h1F) gap_ff <= gap_ff + 5'h01;
  end
  // rising clock edges seen inside one frame
  always_ff @(posedge i_clk) begin
    sclk_d_ff <= sclk;
    if (!i_rstn || cs_n) rise_ff <= 5'h00;
    else if (sclk && !sclk_d_ff) rise_ff <= rise_ff + 5'h01;
  end
  sequence s_setup;
    !sclk [*8];
  endsequence
  sequence s_held_high;
    sclk [*8];
  endsequence
  property p_cs_setup; $fell(cs_n) |-> s_setup; endproperty
  property p_idle_clk; cs_n |-> !sclk; endproperty
  // the flop sees cs_n high one cycle less than it stands
  property p_gap; $fell(cs_n) |-> gap_ff >= 5'h13; endproperty
  property p_high_time; $rose(sclk) |-> s_held_high; endproperty
  property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi); endproperty
  property p_miso_hold; !cs_n && sclk && $past(sclk) |-> $stable(miso); endproperty
  property p_frame_len; $rose(cs_n) |-> rise_ff == 5'h10; endproperty
  // pending events only go away through a status read or mask write
  property p_irq_hold; $fell(irq) |-> !cs_n; endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("clock moved right after select");
  a_idle_clk: assert property (p_idle_clk) else $error("clock active while deselected");
  a_gap: assert property (p_gap) else $error("select gap too short");
  a_high_time: assert property (p_high_time) else $error("clock high phase too short");
  a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while clock high");
  a_miso_hold: assert property (p_miso_hold) else $error("read data moved while clock high");
  a_frame_len: assert property (p_frame_len) else $error("frame without 16 clock rises");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped outside a frame");
endmodule

// ==== test/tb_radio_frame_txrx_control.sv ====
`timescale 1ns/1ps
`include "rft_cfg.svh"
module tb_radio_frame_txrx_control import rft_pkg::*; ;
  localparam int SYM = 8;
  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_oqpsk = 1'h0;
  logic i_rx_start = 1'h0;
  logic i_rx_valid = 1'h0;
  logic i_rx_end = 1'h0;
  logic i_tx_ready = 1'h0;
  logic i_cmd_valid = 1'h0;
  logic i_sleep_tx_trigger_pin = 1'h0;
  logic [2:0] i_cmd_op = 3'h0;
  logic [7:0] i_rx_byte = 8'h00;
  logic [7:0] i_tune_code = 8'h00;
  logic [7:0] i_cmd_data = 8'h00;
  logic o_rx_ready, o_tx_valid, o_tx_shr, o_fe_on, o_cal_busy;
  logic o_cmd_ready, o_rsp_valid, o_irq, o_recal_due;
  logic [7:0] o_tx_byte, o_bb_trim, o_lf_tc, o_rsp_data;
  logic [3:0] o_state;
  int n_fail = 0;
  int total_checks = 0;
  int su = 0;
  int shr = 0;
  logic shr_d = 1'h0;
  logic [8:0] rsp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] rxd[$];
  logic [15:0] tim_q[$];
  logic [8:0] e;
  rft_link_if link();
  rft_device #(.RX_HOLD_CYC(400), .SYM_CYC(SYM)) rft_device_inst (.i_clk(i_clk),
    .i_rstn(i_rstn), .link(link.dev), .i_oqpsk(i_oqpsk), .i_rx_start(i_rx_start),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rx_end(i_rx_end),
    .o_rx_ready(o_rx_ready), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
    .o_tx_byte(o_tx_byte), .o_tx_shr(o_tx_shr), .o_fe_on(o_fe_on), .i_tune_code(i_tune_code),
    .o_cal_busy(o_cal_busy), .o_bb_trim(o_bb_trim), .o_lf_tc(o_lf_tc), .o_state(o_state));
  rft_host #(.RECAL_CYC(40'h1F4)) rft_host_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .link(link.host), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_data(i_cmd_data),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .i_sleep_tx_trigger_pin(i_sleep_tx_trigger_pin), .o_irq(o_irq), .o_recal_due(o_recal_due));
  rft_link_sva rft_link_sva_inst (.i_clk(i_clk), .i_rstn(i_rstn), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .irq(link.irq), .sleep_tx_trigger_pin(link.sleep_tx_trigger_pin));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait; running out fails the run
  task automatic wait_hi(ref logic s);
    int i;
    i = 0;
    while (s !== 1'h1) begin
      @(negedge i_clk);
      i++;
      if (i > 4000) begin
        n_fail++;
        finish_test();
      end
    end
  endtask
  // one 16-bit transfer; the note says what the read should bring
  task automatic xfer(input logic [2:0] op, input logic [7:0] d, input logic c, input logic [7:0] x);
    wait_hi(o_cmd_ready);
    rsp_q.push_back({c, x});
    @(posedge i_clk);
    i_cmd_valid <= 1'h1;
    i_cmd_op <= op;
    i_cmd_data <= d;
    i_tune_code <= $urandom;
    @(posedge i_clk);
    i_cmd_valid <= 1'h0;
    @(negedge i_clk);
    wait_hi(o_cmd_ready);
  endtask
  // one-cycle pulses on the radio side: {tx_ready, rx_end, rx_start}
  task automatic strobe(input logic [2:0] k);
    @(posedge i_clk);
    {i_tx_ready, i_rx_end, i_rx_start} <= k;
    @(posedge i_clk);
    {i_tx_ready, i_rx_end, i_rx_start} <= 3'h0;
    repeat (4) @(negedge i_clk);
  endtask
  // the buffer holds 8; later bytes are refused
  task automatic rx_bytes(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = $urandom;
      if (i < 8) rxd.push_back(b);
      @(posedge i_clk);
      i_rx_valid <= 1'h1;
      i_rx_byte <= b;
      @(posedge i_clk);
      i_rx_valid <= 1'h0;
    end
  endtask
  // monitor: results are matched against the oldest note
  always @(posedge i_clk) begin
    if (o_rsp_valid === 1'h1) begin
      e = rsp_q.pop_front();
      if (e[8]) check("rsp_data", o_rsp_data, e[7:0]);
    end
    if (o_tx_valid === 1'h1) check("tx_byte", o_tx_byte, tx_q.pop_front());
    if (shr_d && o_tx_shr !== 1'h1) begin
      check("startup", su, SYM);
      check("shr_len", shr, tim_q.pop_front());
    end
    shr_d = (o_tx_shr === 1'h1);
    if (o_fe_on !== 1'h1) {su, shr} = 0;
    else if (shr_d) shr++;
    else if (shr == 0) su++;
  end
  initial begin
    void'($urandom(32'hAF93E33F));
    i_tune_code <= $urandom;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'h1;
    repeat (150) @(negedge i_clk);
    check("cal_busy", o_cal_busy, 0);
    check("state", o_state, ST_IDLE);
    check("irq_masked", o_irq, 0);
    check("bb_trim", o_bb_trim, i_tune_code);
    check("lf_tc", o_lf_tc, i_tune_code >> 1);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h08);
    xfer(`RFT_OP_RD_STATE, 8'h00, 1'h1, {1'h1, 3'h0, ST_IDLE});
    xfer(`RFT_OP_WR_MASK, 8'h0F, 1'h0, 8'h00);
    // reception in listen, read too early
    xfer(`RFT_OP_WR_STATE, `RFT_CMD_LISTEN, 1'h0, 8'h00);
    strobe(3'h1);
    rx_bytes(2);
    xfer(`RFT_OP_RD_FB, 8'h00, 1'h1, 8'h00);
    check("irq_line", o_irq, 1);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h05);
    strobe(3'h2);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h02);
    check("irq_clear", o_irq, 0);
    // manual calibration in synthesizer-ready
    xfer(`RFT_OP_WR_STATE, `RFT_CMD_SYN_READY, 1'h0, 8'h00);
    check("recal_due", o_recal_due, 1);
    xfer(`RFT_OP_CAL, 8'h00, 1'h0, 8'h00);
    repeat (100) @(negedge i_clk);
    check("bb_trim2", o_bb_trim, i_tune_code);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h08);
    // reception in auto-ack listen overfills the buffer
    rxd.delete();
    xfer(`RFT_OP_WR_STATE, `RFT_CMD_AACK, 1'h0, 8'h00);
    strobe(3'h1);
    rx_bytes(9);
    check("rx_full", o_rx_ready, 0);
    strobe(3'h2);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h03);
    xfer(`RFT_OP_RD_STATE, 8'h00, 1'h1, {1'h0, 3'h0, ST_AACK});
    while (rxd.size() > 0) xfer(`RFT_OP_RD_FB, 8'h00, 1'h1, rxd.pop_front());
    xfer(`RFT_OP_RD_FB, 8'h00, 1'h1, 8'h00);
    xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h04);
    xfer(`RFT_OP_RD_STATE, 8'h00, 1'h1, {1'h1, 3'h0, ST_AACK});
    // command trigger before filling the buffer, then pin trigger
    for (int m = 0; m < 2; m++) begin
      xfer(`RFT_OP_WR_STATE, m == 1 ? `RFT_CMD_ARET : `RFT_CMD_SYN_READY, 1'h0, 8'h00);
      @(posedge i_clk) i_oqpsk <= m[0];
      tim_q.push_back(16'(SYM * (m == 1 ? 10 : 40)));
      if (m == 0) begin
        xfer(`RFT_OP_WR_STATE, `RFT_CMD_TX_START, 1'h0, 8'h00);
        repeat (41 * SYM + 20) @(negedge i_clk);
        strobe(3'h4);
        xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h04);
      end
      tx_q.push_back(8'(m + 2));
      xfer(`RFT_OP_WR_FB, 8'(m + 2), 1'h0, 8'h00);
      for (int k = 0; k < m + 2; k++) begin
        tx_q.push_back(8'($urandom));
        xfer(`RFT_OP_WR_FB, tx_q[k + 1], 1'h0, 8'h00);
      end
      if (m == 1) begin
        @(posedge i_clk);
        i_sleep_tx_trigger_pin <= 1'h1;
        repeat (11 * SYM + 20) @(posedge i_clk);
        i_sleep_tx_trigger_pin <= 1'h0;
      end
      repeat (m + 3) strobe(3'h4);
      xfer(`RFT_OP_RD_IRQ, 8'h00, 1'h1, 8'h02);
      xfer(`RFT_OP_RD_STATE, 8'h00, 1'h1, {1'h1, 3'h0, m == 1 ? ST_ARET : ST_SYN});
    end
    check("notes_left", 16'(rsp_q.size() + tx_q.size() + tim_q.size()), 0);
    finish_test();
  end
endmodule
